// file: design/chsw_map.vh
// register map, field positions, reset values and widths for the high velocity mode switch
`ifndef CHSW_MAP_VH
`define CHSW_MAP_VH
`define CHSW_ADDR_W        4
`define CHSW_OFF_CTRL      4'h0
`define CHSW_OFF_THRESH    4'h4
`define CHSW_OFF_CHOP      4'h8
`define CHSW_OFF_STATUS    4'hc
`define CHSW_CTRL_FS_BIT   0
`define CHSW_CTRL_CHM_BIT  1
`define CHSW_CTRL_PWM_BIT  2
`define CHSW_CHOP_CHM_BIT  0
`define CHSW_CHOP_DECAY_BIT 1
`define CHSW_CHOP_TOFF_LSB 4
`define CHSW_TOFF_W        4
`define CHSW_TOFF2_W       5
`define CHSW_TSTEP_W       20
`define CHSW_CUR_W         8
`define CHSW_POS_W         10
`define CHSW_POS_45        10'h080
`define CHSW_RST_CTRL      3'h0
`define CHSW_RST_THRESH    20'h00000
`define CHSW_RST_CHOP      6'h00
`define CHSW_RESP_OKAY     2'h0
`define CHSW_RESP_SLVERR   2'h2
`endif

// file: design/chsw_mode_ctl.v
// mode decision: high velocity fullstep, chopper override, pwm gating
`include "chsw_map.vh"
module chsw_mode_ctl (
   // clock and reset
   input  wire                        aclk,
   input  wire                        aresetn,
   // configuration
   input  wire                        fs_en,
   input  wire                        chm_en,
   input  wire                        pwm_en,
   input  wire [`CHSW_TSTEP_W-1:0]    upper_velocity_threshold,
   input  wire                        base_chm,
   input  wire                        base_fast_decay_setting,
   input  wire [`CHSW_TOFF_W-1:0]     base_toff,
   // motion inputs
   input  wire [`CHSW_TSTEP_W-1:0]    step_period,
   input  wire [`CHSW_POS_W-1:0]      elec_pos,
   input  wire                        standstill,
   // outputs
   output reg                         high_vel_ff,
   output reg                         fullstep_ff,
   output reg                         chm_out_ff,
   output reg                         fast_decay_setting_ff,
   output reg  [`CHSW_TOFF2_W-1:0]    toff_out_ff,
   output reg                         pwm_active_ff
);
   wire nxt_high_vel;
   reg  nxt_fullstep;
   reg  nxt_pwm_active;
   wire chm_force;

   assign nxt_high_vel = (step_period <= upper_velocity_threshold);
   assign chm_force    = chm_en & high_vel_ff;

   always @* begin
      nxt_fullstep = fullstep_ff;
      if (!fs_en || !high_vel_ff) begin
         nxt_fullstep = 1'b0;
      end else if (elec_pos == `CHSW_POS_45) begin
         nxt_fullstep = 1'b1;
      end
   end

   always @* begin
      nxt_pwm_active = pwm_active_ff;
      if (!pwm_en) begin
         nxt_pwm_active = 1'b0;
      end else if (!pwm_active_ff && standstill) begin
         nxt_pwm_active = 1'b1;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         high_vel_ff           <= 1'b0;
         fullstep_ff           <= 1'b0;
         chm_out_ff            <= 1'b0;
         fast_decay_setting_ff <= 1'b0;
         toff_out_ff           <= {`CHSW_TOFF2_W{1'b0}};
         pwm_active_ff         <= 1'b0;
      end else begin
         high_vel_ff           <= nxt_high_vel;
         fullstep_ff           <= nxt_fullstep;
         chm_out_ff            <= chm_force ? 1'b1 : base_chm;
         fast_decay_setting_ff <= chm_force ? 1'b0 : base_fast_decay_setting;
         toff_out_ff           <= chm_force ? {base_toff, 1'b0}
                                            : {1'b0, base_toff};
         pwm_active_ff         <= nxt_pwm_active;
      end
   end
endmodule // chsw_mode_ctl

// file: design/chsw_top.v
// high velocity chopper and fullstep switch with axi4-lite registers
`include "chsw_map.vh"
module chsw_top (
   // clock and reset
   input  wire                        aclk,
   input  wire                        aresetn,
   // axi4-lite write address
   input  wire [`CHSW_ADDR_W-1:0]     s_axi_awaddr,
   input  wire                        s_axi_awvalid,
   output wire                        s_axi_awready,
   // axi4-lite write data
   input  wire [31:0]                 s_axi_wdata,
   input  wire [3:0]                  s_axi_wstrb,
   input  wire                        s_axi_wvalid,
   output wire                        s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]                  s_axi_bresp,
   output reg                         s_axi_bvalid,
   input  wire                        s_axi_bready,
   // axi4-lite read address
   input  wire [`CHSW_ADDR_W-1:0]     s_axi_araddr,
   input  wire                        s_axi_arvalid,
   output wire                        s_axi_arready,
   // axi4-lite read data
   output reg  [31:0]                 s_axi_rdata,
   output reg  [1:0]                  s_axi_rresp,
   output reg                         s_axi_rvalid,
   input  wire                        s_axi_rready,
   // motion inputs
   input  wire [`CHSW_TSTEP_W-1:0]    step_period,
   input  wire [`CHSW_POS_W-1:0]      elec_pos,
   input  wire                        standstill,
   input  wire [`CHSW_CUR_W-1:0]      table_cur_a,
   input  wire [`CHSW_CUR_W-1:0]      table_cur_b,
   // drive outputs
   output wire                        high_vel,
   output wire                        fullstep,
   output wire                        chm_out,
   output wire                        fast_decay_setting,
   output wire [`CHSW_TOFF2_W-1:0]    toff_out,
   output wire                        pwm_active,
   output reg  [`CHSW_CUR_W-1:0]      target_cur_a_ff,
   output reg  [`CHSW_CUR_W-1:0]      target_cur_b_ff
);
   reg  [2:0]                 ctrl_ff;
   reg  [`CHSW_TSTEP_W-1:0]   thresh_ff;
   reg  [5:0]                 chop_ff;
   reg  [`CHSW_CUR_W-1:0]     fs_cur_a_ff;
   reg  [`CHSW_CUR_W-1:0]     fs_cur_b_ff;
   reg                        aw_held_ff;
   reg                        w_held_ff;
   reg  [`CHSW_ADDR_W-1:0]    awaddr_ff;
   reg  [31:0]                wdata_ff;
   reg  [3:0]                 wstrb_ff;
   wire                       aw_take;
   wire                       w_take;
   wire                       wr_go;
   wire [`CHSW_ADDR_W-1:0]    wr_addr;
   wire [31:0]                wr_data;
   wire [3:0]                 wr_strb;
   wire                       wr_ok;
   reg  [31:0]                rd_word;
   wire [31:0]                status_word;

   function mapped;
      input [`CHSW_ADDR_W-1:0] a;
      begin
         mapped = (a == `CHSW_OFF_CTRL) || (a == `CHSW_OFF_THRESH) ||
                  (a == `CHSW_OFF_CHOP) || (a == `CHSW_OFF_STATUS);
      end
   endfunction

   // write channels taken in either order, response after both
   assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_ff && !s_axi_bvalid;
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take  = s_axi_wvalid && s_axi_wready;
   assign wr_go   = (aw_held_ff || aw_take) && (w_held_ff || w_take);
   assign wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
   assign wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
   assign wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;
   assign s_axi_arready = !s_axi_rvalid;
   // unmapped addresses and the read-only status refuse writes
   assign wr_ok = mapped(wr_addr) && (wr_addr != `CHSW_OFF_STATUS);

   // a write lands with its response, once both halves are in
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff   <= 1'b0;
         w_held_ff    <= 1'b0;
         awaddr_ff    <= {`CHSW_ADDR_W{1'b0}};
         wdata_ff     <= 32'h00000000;
         wstrb_ff     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `CHSW_RESP_OKAY;
         ctrl_ff      <= `CHSW_RST_CTRL;
         thresh_ff    <= `CHSW_RST_THRESH;
         chop_ff      <= `CHSW_RST_CHOP;
      end else begin
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_go) begin
            aw_held_ff   <= 1'b0;
            w_held_ff    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `CHSW_RESP_OKAY : `CHSW_RESP_SLVERR;
            if (wr_addr == `CHSW_OFF_CTRL && wr_strb[0]) begin
               ctrl_ff <= wr_data[2:0];
            end
            if (wr_addr == `CHSW_OFF_CHOP && wr_strb[0]) begin
               chop_ff <= {wr_data[7:4], wr_data[1:0]};
            end
            if (wr_addr == `CHSW_OFF_THRESH) begin
               if (wr_strb[0]) thresh_ff[7:0]   <= wr_data[7:0];
               if (wr_strb[1]) thresh_ff[15:8]  <= wr_data[15:8];
               if (wr_strb[2]) thresh_ff[19:16] <= wr_data[19:16];
            end
         end else begin
            if (aw_take) begin
               aw_held_ff <= 1'b1;
               awaddr_ff  <= s_axi_awaddr;
            end
            if (w_take) begin
               w_held_ff <= 1'b1;
               wdata_ff  <= s_axi_wdata;
               wstrb_ff  <= s_axi_wstrb;
            end
         end
      end
   end

   // status: toff in [10:6], flags in [4:0]
   assign status_word = {21'h000000, toff_out, 1'b0, pwm_active, fast_decay_setting,
                         chm_out, fullstep, high_vel};

   always @* begin
      rd_word = 32'h00000000;
      case (s_axi_araddr)
         `CHSW_OFF_CTRL: begin
            rd_word = {29'h00000000, ctrl_ff};
         end
         `CHSW_OFF_THRESH: begin
            rd_word = {12'h000, thresh_ff};
         end
         `CHSW_OFF_CHOP: begin
            rd_word = {24'h000000, chop_ff[5:2], 2'h0, chop_ff[1:0]};
         end
         `CHSW_OFF_STATUS: begin
            rd_word = status_word;
         end
         default: begin
            rd_word = 32'h00000000;
         end
      endcase
   end

   // read data registered with the address handshake
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `CHSW_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= mapped(s_axi_araddr) ? `CHSW_RESP_OKAY : `CHSW_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   chsw_mode_ctl u_mode (
      .aclk                     (aclk),
      .aresetn                  (aresetn),
      .fs_en                    (ctrl_ff[`CHSW_CTRL_FS_BIT]),
      .chm_en                   (ctrl_ff[`CHSW_CTRL_CHM_BIT]),
      .pwm_en                   (ctrl_ff[`CHSW_CTRL_PWM_BIT]),
      .upper_velocity_threshold (thresh_ff),
      .base_chm                 (chop_ff[`CHSW_CHOP_CHM_BIT]),
      .base_fast_decay_setting  (chop_ff[`CHSW_CHOP_DECAY_BIT]),
      .base_toff                (chop_ff[5:2]),
      .step_period              (step_period),
      .elec_pos                 (elec_pos),
      .standstill               (standstill),
      .high_vel_ff              (high_vel),
      .fullstep_ff              (fullstep),
      .chm_out_ff               (chm_out),
      .fast_decay_setting_ff    (fast_decay_setting),
      .toff_out_ff              (toff_out),
      .pwm_active_ff            (pwm_active)
   );

   // latch table currents at 45 degrees; use them while in fullstep
   always @(posedge aclk) begin
      if (!aresetn) begin
         fs_cur_a_ff     <= {`CHSW_CUR_W{1'b0}};
         fs_cur_b_ff     <= {`CHSW_CUR_W{1'b0}};
         target_cur_a_ff <= {`CHSW_CUR_W{1'b0}};
         target_cur_b_ff <= {`CHSW_CUR_W{1'b0}};
      end else begin
         if (elec_pos == `CHSW_POS_45) begin
            fs_cur_a_ff <= table_cur_a;
            fs_cur_b_ff <= table_cur_b;
         end
         target_cur_a_ff <= fullstep ? fs_cur_a_ff : table_cur_a;
         target_cur_b_ff <= fullstep ? fs_cur_b_ff : table_cur_b;
      end
   end
endmodule // chsw_top

// file: test/chsw_chk.sv
// assertions for the high velocity mode switch, bound to its top
`include "chsw_map.vh"
module chsw_chk (
   // clock and reset
   input logic        aclk,
   input logic        aresetn,
   // register bus
   input logic [3:0]  s_axi_awaddr,
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic        s_axi_rvalid,
   // motion and drive
   input logic [19:0] step_period,
   input logic [9:0]  elec_pos,
   input logic        standstill,
   input logic        high_vel,
   input logic        fullstep,
   input logic        chm_out,
   input logic        fast_decay_setting,
   input logic [4:0]  toff_out,
   input logic        pwm_active
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [2:0]  ctl_ff;
   logic [19:0] thr_ff;
   logic [7:0]  chop_ff;
   wire         wr_hit = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   // shadow of the configuration registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctl_ff  <= 3'h0;
         thr_ff  <= 20'h00000;
         chop_ff <= 8'h00;
      end else begin
         if (wr_hit && s_axi_awaddr == `CHSW_OFF_CTRL) ctl_ff <= s_axi_wdata[2:0];
         if (wr_hit && s_axi_awaddr == `CHSW_OFF_THRESH) thr_ff <= s_axi_wdata[19:0];
         if (wr_hit && s_axi_awaddr == `CHSW_OFF_CHOP) chop_ff <= s_axi_wdata[7:0];
      end
   end
   sequence s_wr_take; wr_hit; endsequence
   sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
   property p_wr_answer; s_wr_take |=> s_axi_bvalid; endproperty
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   property p_rd_answer; s_rd_take |=> s_axi_rvalid; endproperty
   property p_hv; high_vel == $past(step_period <= thr_ff); endproperty
   property p_fs_entry; $rose(fullstep) |-> $past(elec_pos) == `CHSW_POS_45 && $past(high_vel);
   endproperty
   property p_fs_gate; fullstep |-> $past(high_vel && ctl_ff[0]); endproperty
   property p_chop_force; $past(high_vel && ctl_ff[1]) |->
      chm_out && !fast_decay_setting && toff_out == {$past(chop_ff[7:4]), 1'b0}; endproperty
   property p_chop_keep; $past(!high_vel || !ctl_ff[1]) |-> chm_out == $past(chop_ff[0])
      && fast_decay_setting == $past(chop_ff[1]) && toff_out == {1'b0, $past(chop_ff[7:4])};
   endproperty
   property p_both; $past(fullstep && high_vel && ctl_ff == 3'h3) |-> fullstep && chm_out;
   endproperty
   property p_pwm_on; $rose(pwm_active) |-> $past(standstill && ctl_ff[2]); endproperty
   property p_pwm_off; !$past(ctl_ff[2]) |-> !pwm_active; endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
   a_hv: assert property (p_hv) else $error("high velocity flag wrong");
   a_fs_entry: assert property (p_fs_entry) else $error("fullstep off position");
   a_fs_gate: assert property (p_fs_gate) else $error("fullstep not allowed");
   a_chop_force: assert property (p_chop_force) else $error("chopper not forced");
   a_chop_keep: assert property (p_chop_keep) else $error("chopper mode altered");
   a_both: assert property (p_both) else $error("combined modes lost");
   a_pwm_on: assert property (p_pwm_on) else $error("pwm on while moving");
   a_pwm_off: assert property (p_pwm_off) else $error("pwm on while disabled");
endmodule // chsw_chk
bind chsw_top chsw_chk u_chk (.*);

// file: test/chopper_high_velocity_mode_switch_tb_top.sv
// self-checking bench for the high velocity mode switch
`include "chsw_map.vh"
module chopper_high_velocity_mode_switch_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk, aresetn, standstill, high_vel, fullstep, chm_out, fast_decay_setting, pwm_active;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [19:0] step_period;
   logic [9:0]  elec_pos;
   logic [7:0]  table_cur_a, table_cur_b, target_cur_a_ff, target_cur_b_ff;
   logic [4:0]  toff_out;
   int          mismatches, n_compared, cycles;
   chsw_top u_dut (.*);
   initial begin
      aclk = 0;
      forever #25 aclk = ~aclk;
   end
   task stop_test;
      if (mismatches == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         mismatches++;
         stop_test();
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      logic aw_ok, w_ok, b_ok;
      aw_ok = 0;
      w_ok = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(negedge aclk);
         aw_ok = aw_ok || (s_axi_awvalid && s_axi_awready);
         w_ok = w_ok || (s_axi_wvalid && s_axi_wready);
         b_ok = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge aclk);
         if (aw_ok) s_axi_awvalid <= 0;
         if (w_ok) s_axi_wvalid <= 0;
      end while (!b_ok);
      s_axi_bready <= 0;
   endtask
   task rd(input logic [3:0] a);
      logic ar_ok, r_ok;
      ar_ok = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(negedge aclk);
         ar_ok = ar_ok || (s_axi_arvalid && s_axi_arready);
         r_ok = s_axi_rvalid;
         rd_data = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge aclk);
         if (ar_ok) s_axi_arvalid <= 0;
      end while (!r_ok);
      s_axi_rready <= 0;
   endtask
   // mode outputs as {hv, fs, chm, decay, pwm, toff}
   task md(input logic [9:0] exp);
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk({high_vel, fullstep, chm_out, fast_decay_setting, pwm_active, toff_out}, exp);
      @(posedge aclk);
   endtask
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, standstill, elec_pos} = 0;
      {table_cur_a, table_cur_b} = 16'h0000;
      s_axi_wstrb = 4'hf;
      step_period = 20'h00fff;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      rd(`CHSW_OFF_STATUS);
      chk(rd_data, 32'h00000000);
      rd(4'h2);
      chk(resp, `CHSW_RESP_SLVERR);
      wr(`CHSW_OFF_STATUS, 32'h00000001);
      chk(resp, `CHSW_RESP_SLVERR);
      wr(`CHSW_OFF_THRESH, 32'h00000064);
      chk(resp, `CHSW_RESP_OKAY);
      wr(`CHSW_OFF_CHOP, 32'h00000052);
      rd(`CHSW_OFF_CHOP);
      chk(rd_data, 32'h00000052);
      step_period <= 20'h00064;
      md(10'h245);
      step_period <= 20'h00065;
      md(10'h045);
      wr(`CHSW_OFF_CTRL, 32'h00000002);
      md(10'h045);
      step_period <= 20'h00064;
      md(10'h28a);
      table_cur_a <= 8'h55;
      table_cur_b <= 8'h66;
      elec_pos <= 10'h040;
      wr(`CHSW_OFF_CTRL, 32'h00000003);
      md(10'h28a);
      elec_pos <= 10'h080;
      md(10'h38a);
      elec_pos <= 10'h100;
      table_cur_a <= 8'h11;
      table_cur_b <= 8'h22;
      md(10'h38a);
      @(negedge aclk);
      chk({target_cur_a_ff, target_cur_b_ff}, 32'h00005566);
      @(posedge aclk);
      step_period <= 20'h00065;
      md(10'h045);
      step_period <= 20'h00064;
      elec_pos <= 10'h080;
      wr(`CHSW_OFF_CTRL, 32'h00000002);
      md(10'h28a);
      wr(`CHSW_OFF_CTRL, 32'h00000004);
      md(10'h245);
      standstill <= 1;
      md(10'h265);
      rd(`CHSW_OFF_STATUS);
      chk(rd_data, 32'h00000159);
      rd(`CHSW_OFF_CTRL);
      chk(rd_data, 32'h00000004);
      wr(`CHSW_OFF_CTRL, 32'h00000000);
      md(10'h245);
      @(negedge aclk);
      chk({target_cur_a_ff, target_cur_b_ff}, 32'h00001122);
      stop_test();
   end
endmodule // chopper_high_velocity_mode_switch_tb_top
